// ==== hw/irq_vector_target_event.sv ====
// Interrupt vectors, handler return, user-function opcodes and the
// target-reached event of the command interpreter.
// Assumes the rest of the interpreter feeds program instructions, the
// live context, interrupt source pulses and move start/reached status.

`default_nettype none

module irq_vector_target_event
  import irq_cmd_pkg::*;
(
  // Clock and reset
  input  wire logic                         ref_clk_i,
  input  wire logic                         resetn_i,
  // Host frames in
  input  wire logic                         rx_valid_i,
  input  wire logic [7:0]                   rx_byte_i,
  // Host replies out
  output logic                              tx_valid_o,
  output logic [7:0]                        tx_byte_o,
  input  wire logic                         tx_ready_i,
  output logic                              frame_error_o,
  // Stored-program instruction
  input  wire logic                         prog_valid_i,
  input  wire logic [7:0]                   prog_op_i,
  input  wire logic [7:0]                   prog_type_i,
  input  wire logic [irq_cmd_pkg::WORD_W-1:0] prog_value_i,
  input  wire logic                         prog_running_i,
  // Live context
  input  wire logic [irq_cmd_pkg::WORD_W-1:0] acc_i,
  input  wire logic [irq_cmd_pkg::WORD_W-1:0] x_i,
  input  wire logic [irq_cmd_pkg::FLAGS_W-1:0] flags_i,
  input  wire logic [irq_cmd_pkg::WORD_W-1:0] pc_i,
  // Context restore and vector jump
  output logic                              ctx_load_o,
  output logic [irq_cmd_pkg::WORD_W-1:0]    acc_o,
  output logic [irq_cmd_pkg::WORD_W-1:0]    x_o,
  output logic [irq_cmd_pkg::FLAGS_W-1:0]   flags_o,
  output logic [irq_cmd_pkg::WORD_W-1:0]    pc_o,
  output logic                              vector_jump_o,
  output logic [irq_cmd_pkg::WORD_W-1:0]    vector_pc_o,
  output logic                              in_handler_o,
  // Interrupt sources
  input  wire logic [irq_cmd_pkg::SLOT_COUNT-1:0] irq_src_i,
  // Motion
  input  wire logic                         move_start_i,
  input  wire logic                         pos_reached_i,
  // User functions
  output logic                              uf_strobe_o,
  output logic [7:0]                        uf_op_o,
  output logic [7:0]                        uf_type_o,
  output logic [7:0]                        uf_bank_o,
  output logic [irq_cmd_pkg::WORD_W-1:0]    uf_value_o,
  input  wire logic [irq_cmd_pkg::WORD_W-1:0] uf_result_i
);
  import irq_cmd_pkg::*;

  function automatic logic [IDX_W-1:0] lowest(
    input logic [SLOT_COUNT-1:0] v);
    logic [IDX_W-1:0] r;
    r = '0;
    for (int i = SLOT_COUNT - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = IDX_W'(i);
      end
    end
    return r;
  endfunction

  // Receive side
  logic [7:0]          rx_buf [8];
  logic [3:0]          rx_count;
  wire  [63:0]         rx_flat;
  logic                host_pend;
  logic [7:0]          host_op;
  logic [7:0]          host_type;
  logic [WORD_W-1:0]   host_value;

  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_flat
      assign rx_flat[8*g +: 8] = rx_buf[g];
    end
  endgenerate

  wire rx_last  = rx_valid_i && rx_count == LAST_BYTE;
  // Checksum check on the ninth byte
  wire sum_ok   = rx_byte_i == sum8(rx_flat);
  // Byte order of a command frame
  wire frame_ok = rx_last && sum_ok && rx_buf[0] == MODULE_ADDR;

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rx_count      <= 4'h0;
      frame_error_o <= 1'b0;
      for (int i = 0; i < 8; i++)
      begin
        rx_buf[i] <= 8'h00;
      end
    end
    else
    begin
      frame_error_o <= rx_last && !sum_ok;
      if (rx_last)
      begin
        rx_count <= 4'h0;
      end
      else if (rx_valid_i)
      begin
        rx_buf[rx_count[2:0]] <= rx_byte_i;
        rx_count              <= rx_count + 4'h1;
      end
    end
  end

  // Execution select: a program step goes first, a host frame waits
  wire               exec_host = host_pend && !prog_valid_i;
  wire               exec_go   = exec_host || prog_valid_i;
  wire [7:0]         ex_op     = exec_host ? host_op : prog_op_i;
  wire [7:0]         ex_type   = exec_host ? host_type : prog_type_i;
  wire [WORD_W-1:0]  ex_value  = exec_host ? host_value : prog_value_i;
  wire               is_define = exec_go && ex_op == OP_DEFINE_VECTOR;
  wire               is_return = exec_go && ex_op == OP_RETURN;
  wire               is_int_on = exec_go && ex_op == OP_INT_ENABLE;
  wire               is_int_off = exec_go && ex_op == OP_INT_DISABLE;
  wire               is_uf     = exec_host && ex_op >= OP_USER_FIRST
                                 && ex_op <= OP_USER_LAST;
  wire               is_evt    = exec_host && ex_op == OP_TARGET_EVENT;
  wire               ok_reply  = exec_host && (ex_op == OP_DEFINE_VECTOR
                                 || ex_op == OP_RETURN
                                 || ex_op == OP_INT_ENABLE
                                 || ex_op == OP_INT_DISABLE);
  wire               type_in   = ex_type < 8'(SLOT_COUNT);
  wire [IDX_W-1:0]   type_idx  = ex_type[IDX_W-1:0];

  // Interrupt state
  logic [WORD_W-1:0]     vector [SLOT_COUNT];
  logic [SLOT_COUNT-1:0] vec_def;
  logic [SLOT_COUNT-1:0] irq_en;
  logic [SLOT_COUNT-1:0] irq_pend;
  logic                  global_en;
  wire  [SLOT_COUNT-1:0] ready_set = irq_pend & irq_en & vec_def;
  wire  [IDX_W-1:0]      take_idx  = lowest(ready_set);
  // Taken only between instructions, never nested
  wire take = prog_running_i && global_en && !in_handler_o
              && |ready_set && !prog_valid_i;
  wire [SLOT_COUNT-1:0] take_mask = take ?
       (SLOT_COUNT'(1) << take_idx) : '0;

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      vec_def   <= '0;
      irq_en    <= '0;
      global_en <= 1'b0;
      for (int i = 0; i < SLOT_COUNT; i++)
      begin
        vector[i] <= '0;
      end
    end
    else
    begin
      // Store or replace a handler address
      if (is_define && type_in)
      begin
        vector[type_idx]  <= ex_value;
        vec_def[type_idx] <= 1'b1;
      end
      if (is_int_on && ex_type == IRQ_GLOBAL)
        global_en <= 1'b1;
      else if (is_int_on && type_in)
        irq_en[type_idx] <= 1'b1;
      if (is_int_off && ex_type == IRQ_GLOBAL)
        global_en <= 1'b0;
      else if (is_int_off && type_in)
        irq_en[type_idx] <= 1'b0;
    end
  end

  // Saved context and handler entry/exit
  logic [WORD_W-1:0]  save_acc;
  logic [WORD_W-1:0]  save_x;
  logic [FLAGS_W-1:0] save_flags;
  logic [WORD_W-1:0]  save_pc;

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      irq_pend      <= '0;
      in_handler_o  <= 1'b0;
      vector_jump_o <= 1'b0;
      vector_pc_o   <= '0;
      ctx_load_o    <= 1'b0;
      acc_o         <= '0;
      x_o           <= '0;
      flags_o       <= '0;
      pc_o          <= '0;
      save_acc      <= '0;
      save_x        <= '0;
      save_flags    <= '0;
      save_pc       <= '0;
    end
    else
    begin
      // New source pulse wins over the clear of a taken request
      irq_pend      <= (irq_pend & ~take_mask) | irq_src_i;
      vector_jump_o <= take;
      ctx_load_o    <= is_return && in_handler_o;
      // Save context, then jump to the vector
      if (take)
      begin
        save_acc     <= acc_i;
        save_x       <= x_i;
        save_flags   <= flags_i;
        save_pc      <= pc_i;
        vector_pc_o  <= vector[take_idx];
        in_handler_o <= 1'b1;
      end
      // Leave the handler with context restored
      else if (is_return && in_handler_o)
      begin
        acc_o        <= save_acc;
        x_o          <= save_x;
        flags_o      <= save_flags;
        pc_o         <= save_pc;
        in_handler_o <= 1'b0;
      end
    end
  end

  // Target-reached arming and reply scheduling
  logic               arm_once;
  logic               arm_every;
  logic [7:0]         motor_mask;
  logic               tracking;
  logic               reached_prev;
  logic               uf_wait;
  logic               imm_pend;
  logic [7:0]         imm_cmd;
  logic [WORD_W-1:0]  imm_value;
  logic               evt_pend;
  wire                framer_busy;
  wire                send_imm = !framer_busy && imm_pend;
  wire                send_evt = !framer_busy && !imm_pend && evt_pend;
  wire                arm_hit  = move_start_i && motor_mask[0]
                                 && (arm_once || arm_every);
  wire                reached  = tracking && pos_reached_i
                                 && !reached_prev;

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      host_pend    <= 1'b0;
      host_op      <= 8'h00;
      host_type    <= 8'h00;
      host_value   <= '0;
      arm_once     <= 1'b0;
      arm_every    <= 1'b0;
      motor_mask   <= 8'h00;
      tracking     <= 1'b0;
      reached_prev <= 1'b0;
      uf_wait      <= 1'b0;
      uf_strobe_o  <= 1'b0;
      uf_op_o      <= 8'h00;
      uf_type_o    <= 8'h00;
      uf_bank_o    <= 8'h00;
      uf_value_o   <= '0;
      imm_pend     <= 1'b0;
      imm_cmd      <= 8'h00;
      imm_value    <= '0;
      evt_pend     <= 1'b0;
    end
    else
    begin
      if (frame_ok)
      begin
        host_pend  <= 1'b1;
        host_op    <= rx_buf[1];
        host_type  <= rx_buf[2];
        host_value <= {rx_buf[4], rx_buf[5], rx_buf[6], rx_buf[7]};
      end
      else if (exec_host)
      begin
        host_pend <= 1'b0;
      end
      reached_prev <= pos_reached_i;
      // User opcodes go out, reply follows with the result
      uf_strobe_o  <= is_uf;
      uf_wait      <= is_uf;
      if (is_uf)
      begin
        uf_op_o    <= ex_op;
        uf_type_o  <= ex_type;
        uf_bank_o  <= rx_buf[3];
        uf_value_o <= ex_value;
      end
      // Only host frames arm the event
      if (is_evt)
      begin
        motor_mask <= ex_value[7:0];
        arm_once   <= ex_type == TYPE_NEXT_ONLY;
        arm_every  <= ex_type == TYPE_EVERY;
      end
      else if (arm_hit)
      begin
        arm_once <= 1'b0;
      end
      if (arm_hit)
        tracking <= 1'b1;
      else if (reached)
        tracking <= 1'b0;
      if (ok_reply || is_evt || uf_wait)
      begin
        imm_pend  <= 1'b1;
        imm_cmd   <= uf_wait ? uf_op_o : ex_op;
        imm_value <= uf_wait ? uf_result_i :
                     is_evt ? {24'h000000, ex_value[7:0]} : '0;
      end
      else if (send_imm)
      begin
        imm_pend <= 1'b0;
      end
      // Second reply when the armed move arrives
      if (reached)
        evt_pend <= 1'b1;
      else if (send_evt)
        evt_pend <= 1'b0;
    end
  end

  reply_framer u_framer
  (
    .ref_clk_i  (ref_clk_i),
    .resetn_i   (resetn_i),
    .start_i    (send_imm || send_evt),
    .status_i   (send_imm ? STATUS_OK : STATUS_REACHED),
    .command_i  (send_imm ? imm_cmd : OP_TARGET_EVENT),
    .value_i    (send_imm ? imm_value : {24'h000000, motor_mask}),
    .busy_o     (framer_busy),
    .tx_valid_o (tx_valid_o),
    .tx_byte_o  (tx_byte_o),
    .tx_ready_i (tx_ready_i)
  );
endmodule // irq_vector_target_event

`default_nettype wire

// ==== hw/irq_cmd_pkg.sv ====
// Constants for the vector, handler-return and target-event commands,
// and the serialiser that sends nine-byte reply frames to the host.
// Assumes one 10 MHz clock and a byte-wide link with valid/ready.
//
// Overview of operation
// - Opcode 37 stores value as handler address for type; replies 100.
// - Interrupt number 0 is the timer 0 interrupt.
// - Opcode 38 ends the active handler; direct use replies 100.
// - Handler return reloads accumulator, X, flags and program counter.
// - Opcodes 64 to 71 are user functions replying 100 and a user value.
// - Opcode 138 replies at once and again when the target is reached.
// - Value of opcode 138 is a motor mask; single motor uses bit 0.
// - Type 0 arms the next move only; type 1 arms every later move.
// - Immediate reply: addresses 01h and 02h, status 64h, command 8Ah.
// - Position-reached reply has the same layout with status 80h.
// - Enable or disable with number 255 switches interrupts globally.
// - Redefining a vector replaces the earlier handler address.

`default_nettype none

package irq_cmd_pkg;
  localparam int FRAME_LEN   = 9;
  localparam int SLOT_COUNT  = 16;
  localparam int IDX_W       = 4;
  localparam int WORD_W      = 32;
  localparam int FLAGS_W     = 8;

  localparam logic [7:0] OP_INT_ENABLE    = 8'h19;
  localparam logic [7:0] OP_INT_DISABLE   = 8'h1a;
  localparam logic [7:0] OP_DEFINE_VECTOR = 8'h25;
  localparam logic [7:0] OP_RETURN        = 8'h26;
  localparam logic [7:0] OP_USER_FIRST    = 8'h40;
  localparam logic [7:0] OP_USER_LAST     = 8'h47;
  localparam logic [7:0] OP_TARGET_EVENT  = 8'h8a;

  localparam logic [7:0] STATUS_OK        = 8'h64;
  localparam logic [7:0] STATUS_REACHED   = 8'h80;
  localparam logic [7:0] MODULE_ADDR      = 8'h01;
  localparam logic [7:0] HOST_ADDR        = 8'h02;
  localparam logic [7:0] IRQ_GLOBAL       = 8'hff;
  localparam logic [7:0] IRQ_TIMER0       = 8'h00;
  localparam logic [7:0] TYPE_NEXT_ONLY   = 8'h00;
  localparam logic [7:0] TYPE_EVERY       = 8'h01;

  localparam logic [3:0] LAST_BYTE        = 4'h8;

  typedef enum logic [1:0]
  {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } tx_state_e;

  // Low byte of the sum of eight bytes, byte 0 in the low lane
  function automatic logic [7:0] sum8(input logic [63:0] v);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      s = s + v[8*i +: 8];
    end
    return s;
  endfunction
endpackage

module reply_framer
  import irq_cmd_pkg::*;
(
  // Clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 resetn_i,
  // Reply request
  input  wire logic                 start_i,
  input  wire logic [7:0]           status_i,
  input  wire logic [7:0]           command_i,
  input  wire logic [WORD_W-1:0]    value_i,
  output logic                      busy_o,
  // Byte stream to the host
  output logic                      tx_valid_o,
  output logic [7:0]                tx_byte_o,
  input  wire logic                 tx_ready_i
);
  tx_state_e           state;
  logic [7:0]          status;
  logic [7:0]          command;
  logic [WORD_W-1:0]   value;
  logic [3:0]          index;
  wire  [7:0]          frame [FRAME_LEN];
  wire  [3:0]          next_index;

  // Fixed reply header and value layout
  assign frame[0] = MODULE_ADDR;
  assign frame[1] = HOST_ADDR;
  assign frame[2] = status;
  assign frame[3] = command;
  assign frame[4] = value[31:24];
  assign frame[5] = value[23:16];
  assign frame[6] = value[15:8];
  assign frame[7] = value[7:0];
  assign frame[8] = sum8({frame[7], frame[6], frame[5], frame[4],
                          frame[3], frame[2], frame[1], frame[0]});
  assign next_index = index + 4'h1;
  assign busy_o     = (state == TX_SEND);

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state      <= TX_IDLE;
      status     <= 8'h00;
      command    <= 8'h00;
      value      <= 32'h0000_0000;
      index      <= 4'h0;
      tx_valid_o <= 1'b0;
      tx_byte_o  <= 8'h00;
    end
    else
    begin
      unique case (state)
        TX_IDLE:
        begin
          if (start_i)
          begin
            status     <= status_i;
            command    <= command_i;
            value      <= value_i;
            index      <= 4'h0;
            tx_valid_o <= 1'b1;
            tx_byte_o  <= MODULE_ADDR;
            state      <= TX_SEND;
          end
        end
        TX_SEND:
        begin
          if (tx_ready_i && index == LAST_BYTE)
          begin
            tx_valid_o <= 1'b0;
            state      <= TX_IDLE;
          end
          else if (tx_ready_i)
          begin
            index     <= next_index;
            tx_byte_o <= frame[next_index];
          end
        end
        default:
        begin
          state <= TX_IDLE;
        end
      endcase
    end
  end
endmodule // reply_framer

`default_nettype wire

// ==== test/irq_cmd_asserts.sv ====
// Checker for reply stream, handler entry and exit, user strobes.
// Bound to irq_vector_target_event; sees its ports only.
`default_nettype none
module irq_cmd_asserts
  import irq_cmd_pkg::*;
(
  // Clock and reset
  input wire logic       ref_clk_i,
  input wire logic       resetn_i,
  // Observed ports
  input wire logic       tx_valid_o,
  input wire logic [7:0] tx_byte_o,
  input wire logic       tx_ready_i,
  input wire logic       frame_error_o,
  input wire logic       prog_valid_i,
  input wire logic [7:0] prog_op_i,
  input wire logic       ctx_load_o,
  input wire logic       vector_jump_o,
  input wire logic       in_handler_o,
  input wire logic       uf_strobe_o,
  input wire logic [7:0] uf_op_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);

  a_tx_holds: assert property (tx_valid_o && !tx_ready_i |=>
    tx_valid_o && $stable(tx_byte_o)) else $error("reply byte dropped");
  a_first_addr: assert property ($rose(tx_valid_o) |->
    tx_byte_o == MODULE_ADDR) else $error("reply not led by address");
  a_err_pulse: assert property (frame_error_o |=>
    !frame_error_o) else $error("frame error held");
  a_ret_restore: assert property (prog_valid_i &&
    prog_op_i == OP_RETURN && in_handler_o |=> ctx_load_o && !in_handler_o)
    else $error("return did not restore");
  a_ctx_cause: assert property (ctx_load_o |->
    $past(prog_valid_i) && $past(prog_op_i) == OP_RETURN &&
    $past(in_handler_o)) else $error("restore without return");
  a_jump_enter: assert property (vector_jump_o |->
    in_handler_o && !$past(in_handler_o)) else $error("bad handler entry");
  a_jump_pulse: assert property (vector_jump_o |=>
    !vector_jump_o) else $error("vector jump held");
  a_uf_range: assert property (uf_strobe_o |->
    uf_op_o >= OP_USER_FIRST && uf_op_o <= OP_USER_LAST)
    else $error("user strobe on other opcode");
  a_uf_pulse: assert property (uf_strobe_o |=>
    !uf_strobe_o) else $error("user strobe held");
endmodule // irq_cmd_asserts

bind irq_vector_target_event irq_cmd_asserts u_chk (.ref_clk_i,
  .resetn_i, .tx_valid_o, .tx_byte_o, .tx_ready_i, .frame_error_o,
  .prog_valid_i, .prog_op_i, .ctx_load_o, .vector_jump_o, .in_handler_o,
  .uf_strobe_o, .uf_op_o);
`default_nettype wire

// ==== test/host_model.sv ====
// Host side of the frame link: sends command frames, collects replies.
// Ready is the inverse of the stall input given by the bench.
`default_nettype none
module host_model
(
  // Clock
  input  wire logic       ref_clk_i,
  // Frame link
  output logic            rx_valid_o,
  output logic [7:0]      rx_byte_o,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_byte_i,
  output logic            tx_ready_o,
  // Stall control
  input  wire logic       stall_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  initial
  begin
    rx_valid_o = 1'b0;
    rx_byte_o  = 8'h00;
  end
  assign tx_ready_o = ~stall_i;
  always @(posedge ref_clk_i)
  begin
    if (tx_valid_i && tx_ready_o)
    begin
      got.push_back(tx_byte_i);
    end
  end
  task automatic send(input logic [63:0] f, input logic bad);
    logic [7:0]  s;
    logic [71:0] w;
    s = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      s = s + f[8*i +: 8];
    end
    w = {f, s ^ {7'h00, bad}};
    for (int i = 8; i >= 0; i--)
    begin
      @(posedge ref_clk_i);
      rx_valid_o <= 1'b1;
      rx_byte_o  <= w[8*i +: 8];
    end
    @(posedge ref_clk_i);
    rx_valid_o <= 1'b0;
    rx_byte_o  <= ~w[7:0];
  endtask
endmodule // host_model
`default_nettype wire

// ==== test/irq_vector_target_event_bench.sv ====
// Bench for irq_vector_target_event: host model on the frame link,
// bench drives program, context, interrupt and motion inputs.
`default_nettype none
module irq_vector_target_event_bench
  import irq_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk_i, resetn_i, rx_valid_i, tx_valid_o, tx_ready_i;
  logic        frame_error_o, prog_valid_i, prog_running_i, ctx_load_o;
  logic        vector_jump_o, in_handler_o, move_start_i, pos_reached_i;
  logic        uf_strobe_o, stall;
  logic [7:0]  rx_byte_i, tx_byte_o, prog_op_i, prog_type_i, flags_i;
  logic [7:0]  flags_o, uf_op_o, uf_type_o, uf_bank_o, sf;
  logic [31:0] prog_value_i, acc_i, x_i, pc_i, acc_o, x_o, pc_o, a2;
  logic [31:0] vector_pc_o, uf_value_o, uf_result_i, sa, sx, sp, seed;
  logic [15:0] irq_src_i;
  int          fails, checks_done;
  logic [23:0] uf_seen;
  logic [31:0] uf_seen_v;

  irq_vector_target_event u_dut (.ref_clk_i, .resetn_i, .rx_valid_i,
    .rx_byte_i, .tx_valid_o, .tx_byte_o, .tx_ready_i, .frame_error_o,
    .prog_valid_i, .prog_op_i, .prog_type_i, .prog_value_i,
    .prog_running_i, .acc_i, .x_i, .flags_i, .pc_i, .ctx_load_o, .acc_o,
    .x_o, .flags_o, .pc_o, .vector_jump_o, .vector_pc_o, .in_handler_o,
    .irq_src_i, .move_start_i, .pos_reached_i, .uf_strobe_o, .uf_op_o,
    .uf_type_o, .uf_bank_o, .uf_value_o, .uf_result_i);
  host_model u_host (.ref_clk_i, .rx_valid_o(rx_valid_i),
    .rx_byte_o(rx_byte_i), .tx_valid_i(tx_valid_o), .tx_byte_i(tx_byte_o),
    .tx_ready_o(tx_ready_i), .stall_i(stall));

  always #50 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) stall <= (rnd() % 4) == 0;

  // Capture the user-function fields as they are strobed out
  always @(posedge ref_clk_i)
  begin
    if (uf_strobe_o === 1'b1)
    begin
      uf_seen   <= {uf_op_o, uf_type_o, uf_bank_o};
      uf_seen_v <= uf_value_o;
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string n, input logic [31:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  task automatic cmd(input logic [7:0] op, t, input logic [31:0] v,
                     input logic bad);
    u_host.send({8'h01, op, t, 8'h00, v}, bad);
  endtask

  // Waits for nine reply bytes, checks header, value when full is set, and checksum
  task automatic reply(input logic [7:0] st, c, input logic [31:0] v,
                       input logic full);
    logic [7:0] s;
    int         n;
    n = 0;
    while (u_host.got.size() < 9 && n < 400)
    begin
      tick(1);
      n++;
    end
    chk("reply length", 32'd9, 32'(u_host.got.size()));
    if (u_host.got.size() < 9)
    begin
      return;
    end
    s = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      s = s + u_host.got[i];
    end
    chk("reply head", {8'h01, 8'h02, st, c}, {u_host.got[0],
        u_host.got[1], u_host.got[2], u_host.got[3]});
    if (full)
    begin
      chk("reply value", v, {u_host.got[4], u_host.got[5],
          u_host.got[6], u_host.got[7]});
    end
    chk("reply checksum", 32'(s), 32'(u_host.got[8]));
    u_host.got.delete();
  endtask

  task automatic ok(input logic [7:0] op, t, input logic [31:0] v);
    cmd(op, t, v, 1'b0);
    reply(8'h64, op, v, 1'b0);
  endtask

  task automatic fire(input logic e, input logic [31:0] a);
    logic hit;
    hit = 1'b0;
    tick(1);
    irq_src_i <= 16'h0001;
    tick(1);
    irq_src_i <= 16'h0000;
    for (int n = 0; n < 10; n++)
    begin
      tick(1);
      if (vector_jump_o === 1'b1)
      begin
        hit = 1'b1;
        chk("vector address", a, vector_pc_o);
      end
    end
    chk("vector taken", 32'(e), 32'(hit));
  endtask

  task automatic move(input logic e);
    tick(1);
    move_start_i <= 1'b1;
    tick(1);
    move_start_i <= 1'b0;
    tick(2 + rnd() % 20);
    pos_reached_i <= 1'b1;
    if (e)
    begin
      reply(8'h80, 8'h8a, 32'h1, 1'b1);
    end
    else
    begin
      tick(40);
      chk("no event reply", 32'd0, 32'(u_host.got.size()));
    end
    tick(1);
    pos_reached_i <= 1'b0;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    {ref_clk_i, resetn_i, prog_valid_i, prog_running_i} = 4'h0;
    {move_start_i, pos_reached_i, stall} = 3'h0;
    {prog_op_i, prog_type_i, flags_i, irq_src_i} = 40'h0;
    {prog_value_i, acc_i, x_i, pc_i, uf_result_i} = 160'h0;
    seed = 32'h00001ebe;
    fails = 0;
    checks_done = 0;
    tick(16);
    chk("reset outputs", 32'h0, {tx_valid_o, in_handler_o, ctx_load_o});
    resetn_i <= 1'b1;
    tick(2);
    cmd(8'h25, 8'h00, rnd(), 1'b1);
    sa = 32'h0;
    for (int n = 0; n < 20; n++)
    begin
      tick(1);
      sa[0] = sa[0] | (frame_error_o === 1'b1);
    end
    chk("frame error", 32'h1, sa);
    chk("no reply", 32'd0, 32'(u_host.got.size()));
    u_host.send({8'h05, 8'h25, 16'h0000, 32'h0}, 1'b0);
    tick(20);
    chk("wrong address", 32'd0, 32'(u_host.got.size()));
    $display("test bad checksum done");
    a2 = rnd();
    ok(8'h25, 8'h00, rnd());
    ok(8'h25, 8'h00, a2);
    ok(8'h19, 8'h00, 32'h0);
    ok(8'h19, 8'hff, 32'h0);
    prog_running_i <= 1'b1;
    sa = rnd();
    sx = rnd();
    sp = rnd();
    sf = 8'(rnd());
    acc_i <= sa;
    x_i <= sx;
    pc_i <= sp;
    flags_i <= sf;
    fire(1'b1, a2);
    chk("in handler", 32'h1, 32'(in_handler_o));
    acc_i <= ~sa;
    x_i <= ~sx;
    pc_i <= ~sp;
    flags_i <= ~sf;
    tick(1);
    prog_valid_i <= 1'b1;
    prog_op_i <= 8'h26;
    tick(1);
    prog_valid_i <= 1'b0;
    prog_op_i <= 8'hd9;
    tick(1);
    chk("restore strobe", 32'h1, 32'(ctx_load_o));
    chk("restore acc", sa, acc_o);
    chk("restore x", sx, x_o);
    chk("restore pc", sp, pc_o);
    chk("restore flags", 32'(sf), 32'(flags_o));
    ok(8'h26, 8'hff, 32'h0);
    ok(8'h1a, 8'hff, 32'h0);
    fire(1'b0, a2);
    $display("test vectors done");
    for (int k = 0; k < 8; k++)
    begin
      uf_result_i <= rnd();
      sf = 8'(rnd());
      sx = rnd();
      a2 = {8'h00, 8'(8'h40 + k), sf, 8'(rnd())};
      u_host.send({8'h01, a2[23:16], sf, a2[7:0], sx}, 1'b0);
      reply(8'h64, a2[23:16], uf_result_i, 1'b1);
      chk("user fields", a2, {8'h00, uf_seen});
      chk("user value", sx, uf_seen_v);
    end
    $display("test user functions done");
    prog_valid_i <= 1'b1;
    prog_op_i <= 8'h8a;
    prog_type_i <= 8'h01;
    prog_value_i <= 32'h1;
    tick(1);
    prog_valid_i <= 1'b0;
    move(1'b0);
    cmd(8'h8a, 8'h01, 32'h1, 1'b0);
    reply(8'h64, 8'h8a, 32'h1, 1'b1);
    move(1'b1);
    move(1'b1);
    cmd(8'h8a, 8'h00, 32'h1, 1'b0);
    reply(8'h64, 8'h8a, 32'h1, 1'b1);
    move(1'b1);
    move(1'b0);
    $display("test target event done");
    complete_run();
  end

  initial
  begin
    tick(20000);
    fails++;
    $display("ERROR watchdog expected finish seen timeout");
    complete_run();
  end
endmodule // irq_vector_target_event_bench
`default_nettype wire
